// ===== rtl/ocp_map.svh
`ifndef OCP_MAP_SVH
`define OCP_MAP_SVH
// How it works
// - any phase above shared level raises pick-up
// - pick-up drops below 97 percent of level
// - per-phase current to level ratio every cycle
// - level 0.10..50.00 In, step 0.01, default 1.20
// - setting group switch applies while running
// - stage condition normal, start, trip or blocked
// - per-phase start and trip condition bits
// - expected operate time, 5 ms step, follows current on inverse curve
// - signed remaining time to trip while counting
// - highest phase ratio to level, 0.01 step
// - block input sampled at program cycle start
// - unblocked pick-up asserts start and timing
// - blocked pick-up asserts blocked, nothing more
// - block during start behaves like pick-up drop
// - optional second harmonic inrush block, off default
// - fixed and inverse delay characteristics
// - report node operating mode, five values
// - static choice of rms, true rms or peak-to-peak
// - four independent stages

// geometry
`define OCP_NSTG 4
`define OCP_NPH 3
`define OCP_NJOB 5'h10
`define OCP_NRJOB 5'h0c

// per-stage register offsets, stage stride 0x40
`define OCP_OFF_CFG 6'h00
`define OCP_OFF_LVL0 6'h04
`define OCP_OFF_LVL1 6'h08
`define OCP_OFF_DLY 6'h0c
`define OCP_OFF_REL 6'h10
`define OCP_OFF_INRL 6'h14
`define OCP_OFF_STAT 6'h18
`define OCP_OFF_RATIO 6'h1c
`define OCP_OFF_EXPT 6'h20
`define OCP_OFF_REMT 6'h24
`define OCP_OFF_PHR0 6'h28
`define OCP_OFF_PHR1 6'h2c
`define OCP_OFF_PHR2 6'h30

// configuration field positions
`define OCP_CFG_MODE_LSB 0
`define OCP_CFG_MSEL_LSB 3
`define OCP_CFG_CURVE_BIT 5
`define OCP_CFG_INREN_BIT 6
`define OCP_CFG_GRP_BIT 7

// reset values and limits, currents in 0.01 x In
`define OCP_LVL_RST 16'h0078
`define OCP_LVL_MIN 16'h000a
`define OCP_LVL_MAX 16'h1388
`define OCP_DLY_RST 19'h00014
`define OCP_REL_RST 16'h000c
`define OCP_INRL_RST 16'h0001
`define OCP_RATIO_MAX 17'h1e848

// scaling
`define OCP_PCT_SCALE 32'h00000064
`define OCP_RESET_PCT 32'h00000061
`define OCP_INR_SCALE 32'h00002710
`define OCP_RATIO_ONE 17'h00064

// timing: one program cycle per tick
`define OCP_TICK_MS 5
`define OCP_MAX_S 1800
`define OCP_MAXT_TICKS ((`OCP_MAX_S * 1000) / `OCP_TICK_MS)
`endif

// ===== rtl/ocp_pkg.sv
package ocp_pkg;
  typedef enum logic [1:0] {OCP_NORMAL, OCP_START, OCP_TRIP, OCP_BLOCKED} ocp_cond_e;
  typedef enum logic [2:0] {OCP_ON, OCP_MBLOCKED, OCP_TEST, OCP_TEST_BLOCKED, OCP_OFF} ocp_mode_e;
  typedef enum logic [1:0] {OCP_RMS, OCP_TRMS, OCP_PP} ocp_msel_e;
  typedef enum logic {OCP_FIXED, OCP_INVERSE} ocp_curve_e;
  typedef enum logic [1:0] {OCP_IDLE, OCP_RUN, OCP_WAIT, OCP_EVAL} ocp_seq_e;
  typedef logic [15:0] ocp_mag_t;
  typedef logic [16:0] ocp_ratio_t;
  typedef logic [18:0] ocp_ticks_t;

  // settings of one stage
  typedef struct packed {
    ocp_mode_e mode;
    ocp_msel_e msel;
    ocp_curve_e curve;
    logic inr_en;
    logic grp;
    ocp_mag_t lvl0;
    ocp_mag_t lvl1;
    ocp_ticks_t dly;
    logic [15:0] rel;
    logic [15:0] inr_lim;
  } ocp_cfg_s;

  // run state of one stage
  typedef struct packed {
    ocp_cond_e cond;
    logic [2:0] ph_pu;
    logic [2:0] ph_st;
    logic [2:0] ph_tr;
    logic start;
    logic trip;
    logic blocked;
    logic rel_act;
    ocp_ticks_t opcnt;
    logic [15:0] relcnt;
    ocp_ticks_t exp_t;
    ocp_ratio_t max_ratio;
    logic [2:0][16:0] ratio;
  } ocp_stg_s;

  // whole top state
  typedef struct packed {
    ocp_cfg_s [3:0] cfg;
    ocp_stg_s [3:0] stg;
    logic [2:0][15:0] rms;
    logic [2:0][15:0] trms;
    logic [2:0][15:0] pp;
    logic [2:0][15:0] harm;
    logic [3:0] blk_cap;
    logic [3:0] trip_out;
    ocp_seq_e seq;
    logic [4:0] job;
    logic div_go;
    logic [31:0] div_num;
    logic [31:0] div_den;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ocp_st_s;

  // serial divider state
  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [32:0] rem;
    logic [31:0] q;
    logic [31:0] d;
  } ocp_div_s;
endpackage

// ===== rtl/ocp_div.sv
`timescale 1ns/100ps
`default_nettype none
module ocp_div (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic go,
  input wire logic [31:0] num,
  input wire logic [31:0] den,
  // answer
  output logic [31:0] quot,
  output logic done
);
  ocp_pkg::ocp_div_s r, n;
  logic [32:0] sh;

  // one restoring step per clock, zero divisor gives all ones
  always_comb begin
    n = r;
    sh = '0;
    n.done = 1'b0;
    if (go && !r.busy) begin
      n.busy = 1'b1;
      n.cnt = 6'h20;
      n.rem = '0;
      n.q = num;
      n.d = den;
    end else if (r.busy) begin
      sh = {r.rem[31:0], r.q[31]};
      if (sh >= {1'b0, r.d}) begin
        n.rem = sh - {1'b0, r.d};
        n.q = {r.q[30:0], 1'b1};
      end else begin
        n.rem = sh;
        n.q = {r.q[30:0], 1'b0};
      end
      n.cnt = r.cnt - 6'h01;
      if (r.cnt == 6'h01) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign quot = r.q;
  assign done = r.done;
endmodule
`default_nettype wire

// ===== rtl/ocp_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ocp_map.svh"
module ocp_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement front end, one tick per program cycle
  input wire logic meas_tick,
  input wire logic [2:0][15:0] rms_mag,
  input wire logic [2:0][15:0] trms_mag,
  input wire logic [2:0][15:0] pp_mag,
  input wire logic [2:0][15:0] harm2_mag,
  // blocking matrix, one line per stage
  input wire logic [3:0] blk_in,
  // stage outputs
  output logic [3:0] start_o,
  output logic [3:0] trip_o,
  output logic [3:0] blocked_o
);
  ocp_pkg::ocp_st_s r, n;
  ocp_pkg::ocp_cfg_s c;
  ocp_pkg::ocp_stg_s g;
  logic [31:0] quot;
  logic div_done;
  logic [1:0] as;
  logic [5:0] ao;
  logic hit;
  logic [31:0] rd;
  logic [31:0] wd;
  logic [1:0] js;
  logic [1:0] jp;
  logic [15:0] m;
  logic [15:0] lvl;
  logic [2:0] pu;
  logic inr;
  logic blk;
  logic [16:0] mr;
  logic [19:0] rem_t;
  logic [18:0] maxt;

  // pick magnitude of one phase by static selection
  function automatic logic [15:0] pick_mag(input ocp_pkg::ocp_msel_e s,
                                           input logic [15:0] a,
                                           input logic [15:0] b,
                                           input logic [15:0] p);
    logic [15:0] v;
    v = a;
    case (s)
      ocp_pkg::OCP_TRMS: v = b;
      ocp_pkg::OCP_PP: v = p;
      default: v = a;
    endcase
    return v;
  endfunction

  // largest of three phase ratios
  function automatic logic [16:0] max3(input logic [2:0][16:0] v);
    logic [16:0] x;
    x = v[0];
    if (v[1] > x) x = v[1];
    if (v[2] > x) x = v[2];
    return x;
  endfunction

  // clamp a written level into its legal span
  function automatic logic [15:0] clamp_lvl(input logic [15:0] v);
    logic [15:0] x;
    x = v;
    if (v < `OCP_LVL_MIN) x = `OCP_LVL_MIN;
    else if (v > `OCP_LVL_MAX) x = `OCP_LVL_MAX;
    return x;
  endfunction

  // shared divider for ratios and inverse times
  ocp_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .go(r.div_go),
    .num(r.div_num),
    .den(r.div_den),
    .quot(quot),
    .done(div_done)
  );

  // next state: bus, sequencer and stage evaluation
  always_comb begin
    n = r;
    c = '0;
    g = '0;
    as = paddr[7:6];
    ao = paddr[5:0];
    hit = 1'b1;
    rd = '0;
    wd = '0;
    js = '0;
    jp = '0;
    m = '0;
    lvl = '0;
    pu = '0;
    inr = 1'b0;
    blk = 1'b0;
    mr = '0;
    rem_t = '0;
    maxt = 19'(`OCP_MAXT_TICKS);
    n.div_go = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0; // error only stands beside ready

    // setup cycle: decode and latch read data for the access cycle
    if (psel && !penable) begin
      n.pready = 1'b1;
      c = r.cfg[as];
      g = r.stg[as];
      rem_t = {1'b0, g.exp_t} - {1'b0, g.opcnt};
      if (ao == `OCP_OFF_CFG) begin
        rd[`OCP_CFG_MODE_LSB +: 3] = c.mode;
        rd[`OCP_CFG_MSEL_LSB +: 2] = c.msel;
        rd[`OCP_CFG_CURVE_BIT] = c.curve;
        rd[`OCP_CFG_INREN_BIT] = c.inr_en;
        rd[`OCP_CFG_GRP_BIT] = c.grp;
      end else if (ao == `OCP_OFF_LVL0) begin
        rd = {16'h0000, c.lvl0};
      end else if (ao == `OCP_OFF_LVL1) begin
        rd = {16'h0000, c.lvl1};
      end else if (ao == `OCP_OFF_DLY) begin
        rd = {13'h0000, c.dly};
      end else if (ao == `OCP_OFF_REL) begin
        rd = {16'h0000, c.rel};
      end else if (ao == `OCP_OFF_INRL) begin
        rd = {16'h0000, c.inr_lim};
      end else if (ao == `OCP_OFF_STAT) begin
        rd = {20'h00000, c.mode, g.blocked, g.ph_tr, g.ph_st, g.cond};
      end else if (ao == `OCP_OFF_RATIO) begin
        rd = {15'h0000, g.max_ratio};
      end else if (ao == `OCP_OFF_EXPT) begin
        rd = {13'h0000, g.exp_t};
      end else if (ao == `OCP_OFF_REMT) begin
        if (g.start) rd = {{12{rem_t[19]}}, rem_t};
      end else if (ao == `OCP_OFF_PHR0) begin
        rd = {15'h0000, g.ratio[0]};
      end else if (ao == `OCP_OFF_PHR1) begin
        rd = {15'h0000, g.ratio[1]};
      end else if (ao == `OCP_OFF_PHR2) begin
        rd = {15'h0000, g.ratio[2]};
      end else begin
        hit = 1'b0;
      end
      n.prdata = rd;
      n.pslverr = !hit;
    end

    // access cycle: write with byte strobes, settings apply at once
    if (psel && penable && r.pready && pwrite && !r.pslverr) begin
      c = r.cfg[as];
      wd = {ao == `OCP_OFF_CFG ? 24'h000000 : 24'h000000, 8'h00};
      wd[7:0] = pstrb[0] ? pwdata[7:0] : 8'h00;
      wd[15:8] = pstrb[1] ? pwdata[15:8] : 8'h00;
      wd[23:16] = pstrb[2] ? pwdata[23:16] : 8'h00;
      wd[31:24] = pstrb[3] ? pwdata[31:24] : 8'h00;
      if (ao == `OCP_OFF_CFG) begin
        if (pstrb[0]) begin
          c.mode = ocp_pkg::ocp_mode_e'(wd[`OCP_CFG_MODE_LSB +: 3]);
          c.msel = ocp_pkg::ocp_msel_e'(wd[`OCP_CFG_MSEL_LSB +: 2]);
          c.curve = ocp_pkg::ocp_curve_e'(wd[`OCP_CFG_CURVE_BIT]);
          c.inr_en = wd[`OCP_CFG_INREN_BIT];
          c.grp = wd[`OCP_CFG_GRP_BIT];
        end
      end else if (ao == `OCP_OFF_LVL0) begin
        c.lvl0 = clamp_lvl(wd[15:0]);
      end else if (ao == `OCP_OFF_LVL1) begin
        c.lvl1 = clamp_lvl(wd[15:0]);
      end else if (ao == `OCP_OFF_DLY) begin
        c.dly = (wd[18:0] > maxt) ? maxt : wd[18:0];
      end else if (ao == `OCP_OFF_REL) begin
        c.rel = wd[15:0];
      end else if (ao == `OCP_OFF_INRL) begin
        c.inr_lim = wd[15:0];
      end
      n.cfg[as] = c;
    end

    // job index: ratio jobs 0..11, inverse-time jobs 12..15
    if (r.job < `OCP_NRJOB) begin
      js = 2'(r.job / 5'h03);
      jp = 2'(r.job % 5'h03);
    end else begin
      js = r.job[1:0];
    end

    // program cycle sequencer
    case (r.seq)
      ocp_pkg::OCP_IDLE: begin
        if (meas_tick) begin
          n.rms = rms_mag;
          n.trms = trms_mag;
          n.pp = pp_mag;
          n.harm = harm2_mag;
          n.blk_cap = blk_in;
          n.job = '0;
          n.seq = ocp_pkg::OCP_RUN;
        end
      end
      ocp_pkg::OCP_RUN: begin
        c = r.cfg[js];
        if (r.job < `OCP_NRJOB) begin
          m = pick_mag(c.msel, r.rms[jp], r.trms[jp], r.pp[jp]);
          lvl = c.grp ? c.lvl1 : c.lvl0;
          n.div_num = 32'(m) * `OCP_PCT_SCALE;
          n.div_den = 32'(lvl);
        end else begin
          mr = max3(r.stg[js].ratio);
          n.div_num = 32'(c.dly) * `OCP_PCT_SCALE;
          n.div_den = (mr > `OCP_RATIO_ONE) ? 32'(mr - `OCP_RATIO_ONE) : 32'h00000000;
        end
        n.div_go = 1'b1;
        n.seq = ocp_pkg::OCP_WAIT;
      end
      ocp_pkg::OCP_WAIT: begin
        if (div_done) begin
          if (r.job < `OCP_NRJOB) begin
            n.stg[js].ratio[jp] = (quot > 32'(`OCP_RATIO_MAX)) ? `OCP_RATIO_MAX : 17'(quot);
          end else if (r.cfg[js].curve == ocp_pkg::OCP_INVERSE) begin
            if (quot > 32'(maxt)) n.stg[js].exp_t = maxt;
            else if (quot == 32'h00000000) n.stg[js].exp_t = 19'h00001;
            else n.stg[js].exp_t = 19'(quot);
          end
          if (r.job == `OCP_NJOB - 5'h01) begin
            n.seq = ocp_pkg::OCP_EVAL;
          end else begin
            n.job = r.job + 5'h01;
            n.seq = ocp_pkg::OCP_RUN;
          end
        end
      end
      ocp_pkg::OCP_EVAL: begin
        n.seq = ocp_pkg::OCP_IDLE;
        for (int i = 0; i < `OCP_NSTG; i++) begin
          c = r.cfg[i];
          g = n.stg[i];
          lvl = c.grp ? c.lvl1 : c.lvl0;
          inr = 1'b0;
          for (int p = 0; p < `OCP_NPH; p++) begin
            m = pick_mag(c.msel, r.rms[p], r.trms[p], r.pp[p]);
            if (g.ph_pu[p]) begin
              pu[p] = (32'(m) * `OCP_PCT_SCALE) >= (32'(lvl) * `OCP_RESET_PCT);
            end else begin
              pu[p] = m > lvl;
            end
            if (32'(r.harm[p]) * `OCP_INR_SCALE > 32'(c.inr_lim) * 32'(r.rms[p])) begin
              inr = 1'b1;
            end
          end
          blk = r.blk_cap[i] || (c.inr_en && inr) || c.mode == ocp_pkg::OCP_MBLOCKED ||
                c.mode == ocp_pkg::OCP_TEST_BLOCKED;
          if (c.curve == ocp_pkg::OCP_FIXED) g.exp_t = (c.dly == '0) ? 19'h00001 : c.dly;
          g.max_ratio = max3(g.ratio);
          g.ph_pu = pu;
          if (c.mode == ocp_pkg::OCP_OFF) begin
            g.ph_pu = '0;
            g.start = 1'b0;
            g.trip = 1'b0;
            g.blocked = 1'b0;
            g.rel_act = 1'b0;
            g.opcnt = '0;
          end else if (|pu && !blk) begin
            g.start = 1'b1;
            g.rel_act = 1'b0;
            g.blocked = 1'b0;
            if (g.opcnt != maxt) g.opcnt = g.opcnt + 19'h00001;
            if (g.opcnt >= g.exp_t) g.trip = 1'b1;
          end else begin
            if (g.start) begin
              g.rel_act = 1'b1;
              g.relcnt = '0;
            end
            g.start = 1'b0;
            g.trip = 1'b0;
            g.blocked = |pu && blk;
            if (g.rel_act) begin
              if (g.relcnt >= c.rel) begin
                g.rel_act = 1'b0;
                g.opcnt = '0;
              end else begin
                g.relcnt = g.relcnt + 16'h0001;
              end
            end else begin
              g.opcnt = '0;
            end
          end
          g.ph_st = g.start ? pu : 3'b000;
          g.ph_tr = g.trip ? pu : 3'b000;
          if (g.trip) g.cond = ocp_pkg::OCP_TRIP;
          else if (g.start) g.cond = ocp_pkg::OCP_START;
          else if (g.blocked) g.cond = ocp_pkg::OCP_BLOCKED;
          else g.cond = ocp_pkg::OCP_NORMAL;
          n.trip_out[i] = g.trip && c.mode == ocp_pkg::OCP_ON;
          n.stg[i] = g;
        end
      end
      default: n.seq = ocp_pkg::OCP_IDLE;
    endcase
  end

  // state register with default settings at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      for (int i = 0; i < `OCP_NSTG; i++) begin
        r.cfg[i].lvl0 <= `OCP_LVL_RST;
        r.cfg[i].lvl1 <= `OCP_LVL_RST;
        r.cfg[i].dly <= `OCP_DLY_RST;
        r.cfg[i].rel <= `OCP_REL_RST;
        r.cfg[i].inr_lim <= `OCP_INRL_RST;
      end
    end else begin
      r <= n;
    end
  end

  // outputs straight from state
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign trip_o = r.trip_out;
  genvar gi;
  generate
    for (gi = 0; gi < `OCP_NSTG; gi++) begin : g_out
      assign start_o[gi] = r.stg[gi].start;
      assign blocked_o[gi] = r.stg[gi].blocked;
    end
  endgenerate
endmodule
`default_nettype wire

// ===== verif/ocp_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ocp_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // measurement and block
  input wire logic meas_tick,
  input wire logic [3:0] blk_in,
  // stage outputs
  input wire logic [3:0] start_o,
  input wire logic [3:0] trip_o,
  input wire logic [3:0] blocked_o
);
  logic [9:0] age_r;
  logic [3:0] cap_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since the last tick, block lines captured at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_r <= 10'h3ff;
      cap_r <= 4'h0;
    end else if (meas_tick) begin
      age_r <= 10'h000;
      cap_r <= blk_in;
    end else if (age_r != 10'h3ff) begin
      age_r <= age_r + 10'h001;
    end
  end
  // bus answers and stage outputs
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (psel && !penable && paddr[5:0] > 6'h30 |=> pslverr)
    else $error("unmapped offset not refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_out_quiet: assert property (
    !(age_r >= 10'h190 && age_r <= 10'h2bc) |-> $stable({start_o, trip_o, blocked_o}))
    else $error("stage output moved outside evaluation");
  a_block_stops_start: assert property (age_r == 10'h2bc |-> (cap_r & start_o) == 4'h0)
    else $error("start while block sampled");
  a_start_blocked_excl: assert property ((start_o & blocked_o) == 4'h0)
    else $error("start and blocked together");
  a_trip_with_start: assert property ((trip_o & ~start_o) == 4'h0)
    else $error("trip without start");
endmodule
bind ocp_top ocp_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .meas_tick(meas_tick), .blk_in(blk_in),
  .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o));
`default_nettype wire

// ===== verif/ocp_front_end.sv
`timescale 1ns/100ps
`default_nettype none
module ocp_front_end #(parameter int PERIOD = 1000) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // wanted fundamental and second harmonic per phase
  input wire logic [2:0][15:0] fund,
  input wire logic [2:0][15:0] harm,
  // magnitudes per program cycle
  output logic meas_tick,
  output logic [2:0][15:0] rms_mag,
  output logic [2:0][15:0] trms_mag,
  output logic [2:0][15:0] pp_mag,
  output logic [2:0][15:0] harm2_mag
);
  int cnt;
  // periodic tick, magnitudes refreshed just ahead of it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      meas_tick <= 1'b0;
      rms_mag <= '0;
      trms_mag <= '0;
      pp_mag <= '0;
      harm2_mag <= '0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      meas_tick <= (cnt == PERIOD - 2);
      if (cnt == PERIOD - 3) begin
        rms_mag <= fund;
        harm2_mag <= harm;
        for (int i = 0; i < 3; i++) begin
          trms_mag[i] <= fund[i] + 16'h000a;  // harmonics lift true rms
          pp_mag[i] <= {fund[i][14:0], 1'b0};  // twice the amplitude
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/phase_overcurrent_pickup_block_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("mismatch at %0t: %s", $time, msg); \
  end \
end
module phase_overcurrent_pickup_block_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [3:0] blk_in = 4'h0;
  logic [2:0][15:0] fund = '0;
  logic [2:0][15:0] harm = '0;
  logic meas_tick;
  logic [2:0][15:0] rms_mag, trms_mag, pp_mag, harm2_mag;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr;
  logic [3:0] start_o, trip_o, blocked_o;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'hc4};
  logic [31:0] re [6] = '{32'h0, 32'h78, 32'h14, 32'hc, 32'h1, 32'h78};
  ocp_front_end #(.PERIOD(1000)) fe (.pclk(pclk), .presetn(presetn), .fund(fund), .harm(harm),
    .meas_tick(meas_tick), .rms_mag(rms_mag), .trms_mag(trms_mag), .pp_mag(pp_mag),
    .harm2_mag(harm2_mag));
  ocp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_tick(meas_tick), .rms_mag(rms_mag), .trms_mag(trms_mag),
    .pp_mag(pp_mag), .harm2_mag(harm2_mag), .blk_in(blk_in), .start_o(start_o),
    .trip_o(trip_o), .blocked_o(blocked_o));
  // clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // one apb transfer, answer taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for ready at a rising edge, only the run limit ends it
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    `CHK(n, 1, "bus answer late")
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdata, e, $sformatf("read %h", a))
  endtask
  // wait for n evaluations, outputs settle 561 cycles after the tick
  task automatic ev(input int n);
    repeat (n) begin
      @(posedge pclk iff meas_tick === 1'b1);
      repeat (600) @(posedge pclk);
    end
  endtask
  task automatic setb(input logic [15:0] v);
    fund <= {16'h0, v, 16'h0};
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // run limit
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      $display("mismatch at %0t: run too long", $time);
      give_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], re[i]);
    end
    rd(8'h34, 32'h0);
    `CHK(rerr, 1'b1, "unmapped accepted")
    $display("test reset ended");
    apb(1'b1, 8'h0c, 32'h3);
    setb(16'h0079);
    ev(1);
    `CHK(start_o, 4'hf, "start all stages")
    rd(8'h18, 32'h9);
    rd(8'h1c, 32'h64);
    rd(8'h28, 32'h0);
    rd(8'h2c, 32'h64);
    rd(8'h20, 32'h3);
    rd(8'h24, 32'h2);
    ev(2);
    `CHK(trip_o[0], 1'b1, "trip")
    rd(8'h18, 32'h4a);
    setb(16'h0075);
    ev(1);
    `CHK(start_o[0], 1'b1, "hysteresis hold")
    setb(16'h0074);
    ev(1);
    `CHK(start_o[0], 1'b0, "hysteresis drop")
    $display("test pickup ended");
    setb(16'h0096);
    ev(1);
    `CHK(start_o[0], 1'b1, "start")
    blk_in <= 4'h1;
    ev(1);
    `CHK({start_o[0], blocked_o[0]}, 2'b01, "block during start")
    setb(16'h0);
    ev(1);
    `CHK(blocked_o[0], 1'b0, "blocked without pickup")
    setb(16'h0096);
    ev(1);
    `CHK({start_o[0], blocked_o[0]}, 2'b01, "blocked pickup")
    apb(1'b0, 8'h18, 32'h0);
    `CHK({rdata[8], rdata[1:0]}, 3'h7, "blocked status")
    blk_in <= 4'h0;
    $display("test block ended");
    apb(1'b1, 8'h08, 32'hc8);
    apb(1'b1, 8'h00, 32'h80);
    ev(1);
    `CHK(start_o[0], 1'b0, "group two level")
    apb(1'b1, 8'h04, 32'h5);
    rd(8'h04, 32'ha);
    apb(1'b1, 8'h04, 32'hffff);
    rd(8'h04, 32'h1388);
    apb(1'b1, 8'h04, 32'h78);
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, 8'h00, 32'(m));
      ev(1);
      apb(1'b0, 8'h18, 32'h0);
      `CHK(rdata[11:9], 3'(m), "mode status")
      `CHK(blocked_o[0], 1'(m == 1 || m == 3), "mode block")
    end
    $display("test modes ended");
    setb(16'h0073);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 8'h00, 32'(k << 3));
      ev(1);
      `CHK(start_o[0], 1'(k != 0), "magnitude select")
    end
    setb(16'h0096);
    harm <= {3{16'h0001}};
    apb(1'b1, 8'h00, 32'h40);
    ev(1);
    `CHK({start_o[0], blocked_o[0]}, 2'b01, "inrush block")
    harm <= '0;
    apb(1'b1, 8'h00, 32'h20);
    setb(16'h00f0);
    ev(1);
    rd(8'h20, 32'h3);
    rd(8'h1c, 32'hc8);
    setb(16'h0168);
    ev(1);
    rd(8'h20, 32'h1);
    $display("test curves ended");
    give_verdict();
  end
endmodule
`default_nettype wire
